/* File: hdl/mac_tx_config_control.sv */
// transmit configuration register and the frame gating it steers
`timescale 1ns/1ps
`default_nettype none
module mac_tx_config_control #(
	parameter bit HAS_TIMESTAMP = 1'b1
) (
	input  wire logic                       mclk_i,
	input  wire logic                       nrst_i,
	input  wire logic                       reg_wr_i,
	input  wire logic                       reg_rd_i,
	input  wire logic [15:0]                reg_addr_i,
	input  wire logic [31:0]                reg_wdata_i,
	output var  logic [31:0]                reg_rdata_o,
	output var  logic                       reg_rvalid_o,
	input  wire logic [7:0]                 gap_extension_value_i,
	input  wire logic                       ts_cmd_sideband_i,
	input  wire logic [7:0]                 s_data_i,
	input  wire logic                       s_valid_i,
	input  wire logic                       s_last_i,
	input  wire logic                       s_ts_cmd_i,
	input  wire logic                       fcs_ok_i,
	output var  logic [7:0]                 m_data_o,
	output var  logic                       m_valid_o,
	output var  logic                       m_last_o,
	output var  logic                       append_fcs_o,
	output var  logic                       check_fcs_o,
	output var  logic                       ts_cmd_o,
	output var  logic                       frame_error_o,
	output var  logic                       tx_reset_o,
	output var  logic                       duplex_select_o,
	output var  logic                       tx_idle_o
);
	import tx_cfg_pkg::*;

	initial begin
		if (HAS_TIMESTAMP !== 1'b0 && HAS_TIMESTAMP !== 1'b1)
			$error("HAS_TIMESTAMP must be 0 or 1");
	end

	// the gap counter is 8 bits wide and the tag test needs the two type bytes side by side
	initial begin
		if (MIN_GAP_CYCLES == 8'h00)
			$error("minimum gap must be at least one cycle");
		if (TYPE_BYTE_LO != TYPE_BYTE_HI + 1)
			$error("type field bytes must be adjacent");
		if (STD_MAX_LEN <= 16'(TYPE_BYTE_LO))
			$error("maximum length must cover the type field");
	end

	logic [31:0] shadow_q;
	logic [31:0] active_q;
	tx_state_e   state_q;
	logic [7:0]  gap_cnt_q;
	logic [15:0] len_q;
	logic [7:0]  type_hi_q;
	logic        wr_hit;
	logic        soft_rst;
	logic        in_gap;
	logic [7:0]  gap_target;
	logic        tagged_now;
	logic        fwd_last_q;
	logic        drop_last;

	assign wr_hit     = reg_wr_i && (reg_addr_i == TX_CFG_OFFSET);
	assign soft_rst   = wr_hit && reg_wdata_i[BIT_RESET];
	assign in_gap     = (state_q == ST_GAP);
	// extension only ever lengthens, the floor of 12 holds in both modes
	assign gap_target = (active_q[BIT_GAP_EXT] && gap_extension_value_i > MIN_GAP_CYCLES) ? // R9 R16
		gap_extension_value_i : MIN_GAP_CYCLES; // R10
	assign tagged_now = (len_q == 16'(TYPE_BYTE_LO)) &&
		({type_hi_q, s_data_i} == VLAN_TPID); // R5
	// the beats of a frame after its drop never reach the line, so its end is flagged here instead
	assign drop_last  = s_valid_i && s_last_i && (state_q == ST_DROP); // R4 R15

	// software image; reset bit self-clears so it never stores
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shadow_q <= TX_CFG_RESET; // R3 R4 R15
		end else if (soft_rst) begin
			shadow_q <= TX_CFG_RESET; // R14
		end else if (wr_hit) begin
			shadow_q <= reg_wdata_i & TX_CFG_WMASK; // R13
		end
	end

	// settings seen by the datapath move only while idle in the gap, or at once to defaults on a reset write
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			active_q <= TX_CFG_RESET;
		end else if (soft_rst) begin
			active_q <= TX_CFG_RESET; // R14
		end else if (in_gap && !(s_valid_i && gap_cnt_q == 8'h00)) begin
			active_q <= shadow_q; // R14
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o  <= 32'h00000000;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			reg_rdata_o  <= (reg_rd_i && reg_addr_i == TX_CFG_OFFSET) ? shadow_q : 32'h00000000; // R13
		end
	end

	// frame sequencing and gap counting
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q   <= ST_GAP;
			gap_cnt_q <= 8'h00;
			len_q     <= 16'h0000;
			type_hi_q <= 8'h00;
		end else if (soft_rst) begin
			state_q   <= ST_GAP;
			gap_cnt_q <= 8'h00;
			len_q     <= 16'h0000;
		end else begin
			unique case (state_q)
				ST_GAP: begin
					if (gap_cnt_q != 8'h00) begin
						gap_cnt_q <= gap_cnt_q - 8'h01;
					end else if (s_valid_i && active_q[BIT_TX_EN]) begin // R3
						len_q   <= 16'h0001;
						state_q <= s_last_i ? ST_GAP : ST_FRAME;
						if (s_last_i)
							gap_cnt_q <= gap_target;
					end
				end
				ST_FRAME, ST_DROP: begin
					if (s_valid_i) begin
						len_q <= len_q + 16'h0001;
						if (len_q == 16'(TYPE_BYTE_HI))
							type_hi_q <= s_data_i;
						if (state_q == ST_FRAME && tagged_now && !active_q[BIT_VLAN_EN])
							state_q <= ST_DROP; // R4
						// oversize frames are cut off unless allowed
						if (state_q == ST_FRAME && !active_q[BIT_OVERSIZE] && len_q >= STD_MAX_LEN)
							state_q <= ST_DROP; // R15
						if (s_last_i) begin
							state_q   <= ST_GAP;
							gap_cnt_q <= gap_target; // R10
						end
					end
				end
			endcase
		end
	end

	// output stage; the stream has no ready, so a beat is either passed on or lost
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			m_data_o  <= 8'h00;
			m_valid_o <= 1'b0;
			m_last_o  <= 1'b0;
		end else begin
			m_data_o  <= s_data_i;
			m_valid_o <= s_valid_i && active_q[BIT_TX_EN] && !soft_rst && // R3
				((state_q == ST_FRAME) || (state_q == ST_GAP && gap_cnt_q == 8'h00));
			m_last_o  <= s_last_i;
		end
	end

	// the datapath's verdict arrives one cycle after the forwarded last beat
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fwd_last_q <= 1'b0;
		end else begin
			fwd_last_q <= m_valid_o && m_last_o;
		end
	end

	// verdicts outside a forwarded end are meaningless and must not raise an error
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			frame_error_o <= 1'b0;
		end else begin
			frame_error_o <= drop_last || (fwd_last_q && !fcs_ok_i); // R2
		end
	end

	// without timestamping the select bit has no effect
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ts_cmd_o <= 1'b0;
		end else begin
			ts_cmd_o <= HAS_TIMESTAMP ? // R12
				(active_q[BIT_TS_INLINE] ? s_ts_cmd_i : ts_cmd_sideband_i) : 1'b0; // R11
		end
	end

	// check-sequence append follows the active image and checking is on from the first cycle after reset, so neither flips mid-frame
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			append_fcs_o <= 1'b1;
			check_fcs_o  <= 1'b0;
		end else begin
			append_fcs_o <= !active_q[BIT_FCS_INBAND]; // R1
			check_fcs_o  <= 1'b1; // R2
		end
	end

	// status toward the line side; duplex is only passed through, half duplex is unsupported
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_reset_o      <= 1'b0;
			duplex_select_o <= 1'b0;
			tx_idle_o       <= 1'b1;
		end else begin
			tx_reset_o      <= soft_rst; // R14
			duplex_select_o <= active_q[BIT_DUPLEX];
			tx_idle_o       <= in_gap && gap_cnt_q == 8'h00;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/tx_cfg_pkg.sv */
// constants and field layout of the transmit configuration control block
// Contract
// R1 - with the in-band check-sequence bit set the check sequence comes from the frame data, otherwise it is computed and appended.
// R2 - every outgoing frame has its check sequence verified, supplied or generated.
// R3 - bit 28 gates all transmit operation and resets to one.
// R4 - bit 27 resets to zero and permits tagged frames when set, forbids them when clear.
// R5 - a frame counts as tagged only when its type/length field is 0x8100.
// R6 - software keeps the basic tag enable clear while the extended tag mode is in use.
// R7 - software enables oversize frames before using the extended tag function.
// R8 - software leaves the duplex select bit 26 at zero since only full duplex works.
// R9 - with bit 25 set the gap is lengthened to the programmed gap extension value.
// R10 - never fewer than 12 idle cycles pass between frames. A reset write clears the gap count, so the next frame can follow sooner.
// R11 - bit 22 picks the timestamp command source, sideband when zero and in-line when one.
// R12 - without timestamping in the build bit 22 is ignored.
// R13 - bits 24:23 and 21:0 ignore writes and read as zero.
// R14 - writes land any time but settings apply only in the gap, except the reset bit which acts at once.
// R15 - bit 30 resets to zero and allows frames above the standard maximum length when set.
// R16 - with extension on the gap is the larger of the programmed count and 12.
package tx_cfg_pkg;
	localparam logic [15:0] TX_CFG_OFFSET   = 16'h0408;
	localparam int          BIT_RESET       = 31;
	localparam int          BIT_OVERSIZE    = 30;
	localparam int          BIT_FCS_INBAND  = 29;
	localparam int          BIT_TX_EN       = 28;
	localparam int          BIT_VLAN_EN     = 27;
	localparam int          BIT_DUPLEX      = 26;
	localparam int          BIT_GAP_EXT     = 25;
	localparam int          BIT_TS_INLINE   = 22;
	localparam logic [31:0] TX_CFG_WMASK    = 32'h7E400000;
	localparam logic [31:0] TX_CFG_RESET    = 32'h10000000;
	localparam logic [15:0] VLAN_TPID       = 16'h8100;
	localparam logic [7:0]  MIN_GAP_CYCLES  = 8'h0C;
	localparam logic [15:0] STD_MAX_LEN     = 16'h05EE;
	localparam int          TYPE_BYTE_HI    = 12;
	localparam int          TYPE_BYTE_LO    = 13;
	typedef enum logic [1:0] {
		ST_GAP   = 2'b00,
		ST_FRAME = 2'b01,
		ST_DROP  = 2'b10
	} tx_state_e;
endpackage

/* File: sim/mac_tx_config_control_assertions.sv */
// port-level assertions for the transmit configuration block
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_chk import tx_cfg_pkg::*; (
	input wire logic        mclk_i,
	input wire logic        nrst_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic [7:0]  s_data_i,
	input wire logic        s_valid_i,
	input wire logic        fcs_ok_i,
	input wire logic [7:0]  m_data_o,
	input wire logic        m_valid_o,
	input wire logic        m_last_o,
	input wire logic        append_fcs_o,
	input wire logic        check_fcs_o,
	input wire logic        frame_error_o,
	input wire logic        tx_reset_o,
	input wire logic        duplex_select_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	rd_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray read answer");
	rsvd_zero_a: assert property (reg_rvalid_o |-> (reg_rdata_o & ~TX_CFG_WMASK) == 32'h0)
		else $error("reserved bits not zero");
	fwd_data_a: assert property (m_valid_o |-> $past(s_valid_i) && m_data_o == $past(s_data_i))
		else $error("forwarded beat differs");
	gap_min_a: assert property (m_last_o |=> (!m_valid_o)[*8] ##1 (!m_valid_o)[*4])
		else $error("gap shorter than minimum");
	fcs_fail_a: assert property (m_valid_o && m_last_o ##1 !fcs_ok_i |-> ##[0:1] frame_error_o)
		else $error("bad check sequence not flagged");
	check_on_a: assert property (m_valid_o |-> check_fcs_o) else $error("check sequence not verified");
	rst_pulse_a: assert property (reg_wr_i && reg_addr_i == TX_CFG_OFFSET && reg_wdata_i[BIT_RESET]
		|=> tx_reset_o) else $error("reset bit not immediate");
	rst_values_a: assert property (tx_reset_o |=> append_fcs_o && !duplex_select_o)
		else $error("reset did not restore defaults");
	cover property (m_last_o);
	cover property (frame_error_o);
	cover property (tx_reset_o);
endmodule
bind mac_tx_config_control tx_cfg_chk u_chk (.*);
`default_nettype wire

/* File: sim/tx_dp_model.sv */
// datapath model returning the check-sequence verdict
`timescale 1ns/1ps
`default_nettype none
module tx_dp_model (
	input  wire logic mclk_i,
	input  wire logic nrst_i,
	input  wire logic m_last_o,
	input  wire logic bad_i,
	output var  logic fcs_ok_o
);
	// verdict only means something after a last beat, so it toggles elsewhere
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) fcs_ok_o <= 1'b0;
		else fcs_ok_o <= m_last_o ? !bad_i : ~fcs_ok_o;
	end
endmodule
`default_nettype wire

/* File: sim/mac_tx_config_control_tb.sv */
// self-checking bench for the transmit configuration block
`timescale 1ns/1ps
`default_nettype none
module mac_tx_config_control_tb;
	import tx_cfg_pkg::*;
	logic mclk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, s_valid_i = 0, s_last_i = 0, s_ts_cmd_i = 0;
	logic ts_cmd_sideband_i = 0, bad = 0, fcs_ok_i, m_valid_o, m_last_o, frame_error_o, append_fcs_o, tx_idle_o;
	logic [15:0] reg_addr_i = 16'h0, tpid;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, cfg;
	logic [7:0] gap_extension_value_i = 8'h0, s_data_i = 8'h0, ext;
	int errors = 0, checks_done = 0, seed = 32'h521B, nout, nerr, gap, len, g;
	mac_tx_config_control u_mac_tx_config_control (.mclk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
		.reg_wdata_i, .reg_rdata_o, .reg_rvalid_o(), .gap_extension_value_i, .ts_cmd_sideband_i, .s_data_i,
		.s_valid_i, .s_last_i, .s_ts_cmd_i, .fcs_ok_i, .m_data_o(), .m_valid_o, .m_last_o, .append_fcs_o,
		.check_fcs_o(), .ts_cmd_o(), .frame_error_o, .tx_reset_o(), .duplex_select_o(), .tx_idle_o);
	tx_dp_model u_tx_dp_model (.mclk_i, .nrst_i, .m_last_o, .bad_i(bad), .fcs_ok_o(fcs_ok_i));
	initial forever #4 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		nout <= nout + m_valid_o;
		nerr <= nerr + frame_error_o;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
		@(posedge mclk_i) reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge mclk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
		@(posedge mclk_i) reg_rd_i <= 1'b0;
		@(negedge mclk_i) chk(reg_rdata_o, e);
	endtask
	// the stream has no ready, so the source itself waits out the gap
	task frame;
		@(negedge mclk_i) {nout, nerr} = 64'h0;
		for (int i = 0; i < len; i++)
			@(posedge mclk_i) {s_valid_i, s_last_i, s_ts_cmd_i, s_data_i} <= {1'b1, i == len - 1,
				1'($random(seed)), i == 12 ? tpid[15:8] : i == 13 ? tpid[7:0] : 8'($random(seed))};
		@(posedge mclk_i) {s_valid_i, s_last_i} <= 2'b00;
		gap = 0;
		while (!tx_idle_o && gap < 400) @(posedge mclk_i) gap++;
		repeat (3) @(posedge mclk_i);
	endtask
	function automatic int exp_gap(input logic [31:0] c, input logic [7:0] x);
		return (c[BIT_GAP_EXT] && x > MIN_GAP_CYCLES) ? int'(x) : int'(MIN_GAP_CYCLES);
	endfunction
	task final_report;
		if (errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk_i);
		nrst_i <= 1'b1;
		rd(TX_CFG_OFFSET, TX_CFG_RESET);
		for (int k = 0; k < 12; k++) begin
			// no extended tag mode or oversize need here, so the basic tag enable may vary
			// duplex stays clear and transmit stays on, as software must keep them
			cfg = ($random(seed) & TX_CFG_WMASK & ~32'h04000000) | 32'h10000000;
			ext = 8'($random(seed));
			if (k < 2) {cfg[BIT_GAP_EXT], cfg[BIT_VLAN_EN], ext} = {1'b1, k == 1, k == 1 ? 8'hFF : 8'h00};
			tpid = (k < 2 || $random(seed) & 1) ? VLAN_TPID : 16'h8800;
			len = 20 + $unsigned($random(seed)) % 40;
			wr(TX_CFG_OFFSET, cfg | 32'h00800001);
			{gap_extension_value_i, ts_cmd_sideband_i, bad} <= {ext, 2'($random(seed))};
			rd(TX_CFG_OFFSET, cfg);
			chk(append_fcs_o, !cfg[BIT_FCS_INBAND]);
			frame;
			g = exp_gap(cfg, ext);
			chk(tpid == VLAN_TPID && !cfg[BIT_VLAN_EN] ? 1 : bad, nerr);
			if (nerr == 0) chk(nout, len);
			chk(gap >= g && gap <= g + 3, 1);
		end
		wr(TX_CFG_OFFSET, 32'h0);
		frame;
		chk(nout, 0);
		wr(16'h040C, 32'hFFFFFFFF);
		rd(TX_CFG_OFFSET, 32'h0);
		wr(TX_CFG_OFFSET, 32'hE8000000);
		rd(TX_CFG_OFFSET, TX_CFG_RESET);
		final_report;
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		errors++;
		final_report;
	end
endmodule
`default_nettype wire
